// ### dv/pdpo_capture_model.sv
// Downstream capture logic that latches converter words on the strobe.
`timescale 1ns/1ps
`default_nettype none
module pdpo_capture_model (
  input wire logic sampleValidStrobe,
  input wire pdpo_pkg::pdpo_word_t sampleWordLines,
  output pdpo_pkg::pdpo_word_t capturedWord,
  output logic [31:0] captureCount
);
  import pdpo_pkg::*;
  // ==========================================================
  // Capture
  // Start from a known count so the bench can compare totals.
  // One process owns both outputs, so each has a single driver.
  initial
  begin
    capturedWord = 12'h000;
    captureCount = 32'h0;
    // Latch only on the rising strobe, where the word is settled.
    forever
    begin
      @(posedge sampleValidStrobe);
      capturedWord <= sampleWordLines;
      captureCount <= captureCount + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench of the converter output port.
`timescale 1ns/1ps
`default_nettype none
`define PDPO_CHK(what, expv, gotv) \
  begin \
    n_checks++; \
    if ((gotv) !== (expv)) \
    begin \
      bad_count++; \
      $display("ERROR %s expected %0h seen %0h", what, expv, gotv); \
    end \
  end
module testbench;
  import pdpo_pkg::*;
  logic clk;
  logic sampleClk;
  logic nrst;
  pdpo_raw_t rawCode;
  logic [1:0] strap;
  logic lowPowerRequest;
  pdpo_word_t sampleWordLines;
  logic sampleValidStrobe;
  logic dutyCycleStabilizer;
  logic lowPowerActive;
  pdpo_word_t capturedWord;
  logic [31:0] captureCount;
  logic [31:0] capBase;
  pdpo_word_t expQ[$];
  logic armed;
  int bad_count;
  int n_checks;
  int strobeCount;
  int vals[9] = '{-2048, -1024, 0, 1024, 2047, -8192, 8191, -3000, 3000};

  // ==========================================================
  // Design, far side and clocks
  // A short recovery keeps the wake-up scenario within a few microseconds.
  pdpo_port #(.RECOVER_CYCLES(20)) pdpo_port_inst (
    .clk(clk),
    .nrst(nrst),
    .sampleClk(sampleClk),
    .rawCode(rawCode),
    .formatStabilizerStrap(strap),
    .lowPowerRequest(lowPowerRequest),
    .sampleWordLines(sampleWordLines),
    .sampleValidStrobe(sampleValidStrobe),
    .dutyCycleStabilizer(dutyCycleStabilizer),
    .lowPowerActive(lowPowerActive)
  );
  pdpo_capture_model pdpo_capture_model_inst (
    .sampleValidStrobe(sampleValidStrobe),
    .sampleWordLines(sampleWordLines),
    .capturedWord(capturedWord),
    .captureCount(captureCount)
  );
  always #5 clk = ~clk;
  // The sample clock is offset so its edges never line up with clk.
  initial
  begin
    #13;
    forever #40 sampleClk = ~sampleClk;
  end

  // ==========================================================
  // Expected words and drivers
  // Clip first, then offset; two's complement only flips the top bit.
  function automatic pdpo_word_t expw(int r, logic [1:0] s);
    int c;
    c = (r < -2048) ? -2048 : ((r > 2047) ? 2047 : r);
    expw = 12'(c + 2048) ^ {s[1], 11'h000};
  endfunction
  // One new sample per period, with its note queued at once.
  task automatic drive(int v);
    @(posedge sampleClk);
    #1;
    rawCode = pdpo_raw_t'(v);
    expQ.push_back(expw(v, strap));
  endtask
  // Hold a value until the pipe is full of it, then align on a strobe.
  task automatic arm(int v);
    armed = 0;
    @(posedge sampleClk);
    #1;
    rawCode = pdpo_raw_t'(v);
    repeat (12) @(posedge sampleClk);
    expQ.delete();
    @(posedge sampleValidStrobe);
    #3;
    repeat (8) expQ.push_back(expw(v, strap));
    armed = 1;
  endtask
  // Every queued sample must have come out, one word per period.
  task automatic drain();
    repeat (9) @(posedge sampleClk);
    #1;
    `PDPO_CHK("pending words", 0, expQ.size());
    armed = 0;
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Monitor
  // Each capture takes the oldest note; words seen while unarmed are ignored.
  always @(posedge sampleValidStrobe)
  begin
    pdpo_word_t e;
    strobeCount++;
    #1;
    if (armed && expQ.size() > 0)
    begin
      e = expQ.pop_front();
      `PDPO_CHK("sample word", e, capturedWord);
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    clk = 0;
    sampleClk = 0;
    nrst = 0;
    rawCode = '0;
    strap = 2'h0;
    lowPowerRequest = 0;
    armed = 0;
    bad_count = 0;
    n_checks = 0;
    strobeCount = 0;
    void'($urandom(37));
    repeat (5) @(posedge sampleClk);
    #1;
    `PDPO_CHK("strobe in reset", 1'b0, sampleValidStrobe);
    nrst = 1;
    // Strap changes only while unarmed, since words near a change mix.
    for (int s = 0; s < 4; s++)
    begin
      strap = 2'(s);
      arm(0);
      `PDPO_CHK("stab", (s == 1 || s == 2), dutyCycleStabilizer);
      foreach (vals[i]) drive(vals[i]);
      repeat (10) drive(int'($urandom_range(16383)) - 8192);
      drain();
    end
    // Power-down mid-stream, then wake and resume.
    arm(-1024);
    @(posedge clk);
    #1;
    lowPowerRequest = 1;
    repeat (2) @(posedge clk);
    #1;
    `PDPO_CHK("low power early", 1'b0, lowPowerActive);
    @(posedge clk);
    #1;
    `PDPO_CHK("low power", 1'b1, lowPowerActive);
    armed = 0;
    repeat (5) @(posedge sampleClk);
    strobeCount = 0;
    capBase = captureCount;
    repeat (10) @(posedge sampleClk);
    #1;
    `PDPO_CHK("strobes when down", 0, strobeCount);
    `PDPO_CHK("captures when down", capBase, captureCount);
    `PDPO_CHK("word when down", 12'h000, sampleWordLines);
    @(posedge clk);
    #1;
    lowPowerRequest = 0;
    repeat (3) @(posedge clk);
    #1;
    `PDPO_CHK("low power exit", 1'b0, lowPowerActive);
    arm(2047);
    repeat (10) drive(int'($urandom_range(4095)) - 2048);
    drain();
    final_report();
  end

  // ==========================================================
  // Watchdog
  // The run needs about 18 us; some thirteen times that means a hang.
  initial
  begin
    #250000;
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire

// ### include/pdpo_consts.svh
// Constants of the pipelined converter output port.
`ifndef PDPO_CONSTS_SVH
`define PDPO_CONSTS_SVH
`define PDPO_WORD_W 12
`define PDPO_WORD_MSB 11
`define PDPO_RAW_W 14
`define PDPO_PIPE_STAGES 7
`define PDPO_RAW_LO 14'sh3800
`define PDPO_RAW_HI 14'sh07FF
`define PDPO_RAW_QTR_NEG 14'sh3C00
`define PDPO_RAW_MID 14'sh0000
`define PDPO_CODE_ZERO 12'h000
`define PDPO_CODE_QTR 12'h400
`define PDPO_CODE_MID 12'h800
`define PDPO_CODE_FULL 12'hFFF
`define PDPO_RECOVER_MS 3
`define PDPO_US_PER_MS 1000
`define PDPO_CLK_MHZ 100
`define PDPO_CNT_W 20
`define PDPO_STRAP_RST 2'h0
`endif

// ### include/pdpo_pkg.sv
// Types shared by the converter output port modules.
`include "pdpo_consts.svh"
package pdpo_pkg;
  typedef logic [`PDPO_WORD_W-1:0] pdpo_word_t;
  typedef logic signed [`PDPO_RAW_W-1:0] pdpo_raw_t;
  typedef enum logic [1:0] {
    PDPO_STRAP_GND = 2'b00,
    PDPO_STRAP_THIRD = 2'b01,
    PDPO_STRAP_TWO_THIRDS = 2'b10,
    PDPO_STRAP_SUPPLY = 2'b11
  } pdpo_strap_t;
  typedef enum logic [1:0] {
    PDPO_PWR_RUN = 2'b00,
    PDPO_PWR_DOWN = 2'b01,
    PDPO_PWR_WAKE = 2'b10
  } pdpo_pwr_state_t;
  typedef struct packed {
    logic valid;
    pdpo_word_t word;
  } pdpo_stage_t;
  typedef struct packed {
    pdpo_stage_t [`PDPO_PIPE_STAGES-1:0] stage;
  } pdpo_pipe_t;
  typedef struct packed {
    pdpo_pwr_state_t state;
    logic [`PDPO_CNT_W-1:0] count;
    logic lowPower;
    logic ready;
  } pdpo_pwr_t;
  typedef struct packed {
    pdpo_word_t word;
    logic valid;
    logic stab;
  } pdpo_out_t;
endpackage

// ### include/pdpo_word_if.sv
// Word and valid carried between the port and its delay line.
`timescale 1ns/1ps
`default_nettype none
interface pdpo_word_if;
  pdpo_pkg::pdpo_word_t word;
  logic valid;
  modport src (output word, output valid);
  modport dst (input word, input valid);
endinterface
`default_nettype wire

// ### src/pdpo_pipeline.sv
// Fixed-length delay line for conversion results.
`timescale 1ns/1ps
`default_nettype none
`include "pdpo_consts.svh"
module pdpo_pipeline (
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  pdpo_word_if.dst stageIn,
  pdpo_word_if.src stageOut
);
  import pdpo_pkg::*;
  pdpo_pipe_t pipeQ;
  pdpo_pipe_t pipeD;

  // Shift every stage; a flush drops all valid marks at once.
  always_comb
  begin
    pipeD.stage[0].valid = stageIn.valid & ~flush;
    pipeD.stage[0].word = stageIn.word;
    for (int i = 1; i < `PDPO_PIPE_STAGES; i++)
    begin
      pipeD.stage[i].word = pipeQ.stage[i-1].word;
      pipeD.stage[i].valid = pipeQ.stage[i-1].valid & ~flush;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pipeQ <= '0;
    else
      pipeQ <= pipeD;
  end

  assign stageOut.word = pipeQ.stage[`PDPO_PIPE_STAGES-1].word;
  assign stageOut.valid = pipeQ.stage[`PDPO_PIPE_STAGES-1].valid;
endmodule
`default_nettype wire

// ### src/pdpo_port.sv
// Output port of a 12-bit pipelined converter with power control.
//
// Notes on behaviour
// - One new output word per sample clock period.
// - Sample on rising edge; result appears seven clocks later.
// - Each result is a 12-bit parallel word.
// - A strobe at sample rate times each word update.
// - Strap level picks offset binary or two's complement coding.
// - Same strap enables or bypasses the duty-cycle stabilizer.
// - Negative full scale gives 000h or 800h.
// - Quarter range gives 400h or C00h.
// - Mid-scale gives 800h or 000h.
// - Positive full scale gives FFFh or 7FFh.
// - Over-range input clips at full scale, never wraps.
// - Power-down input high enters reduced-power state.
// - Strap: supply, ground, two-thirds, one-third select four modes.
// - Power-down loses pipeline; words resume after about 3 ms.
`timescale 1ns/1ps
`default_nettype none
`include "pdpo_consts.svh"
module pdpo_port #(
  parameter int unsigned RECOVER_CYCLES =
    `PDPO_RECOVER_MS * `PDPO_US_PER_MS * `PDPO_CLK_MHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sampleClk,
  input wire pdpo_pkg::pdpo_raw_t rawCode,
  input wire logic [1:0] formatStabilizerStrap,
  input wire logic lowPowerRequest,
  output logic [`PDPO_WORD_W-1:0] sampleWordLines,
  output logic sampleValidStrobe,
  output logic dutyCycleStabilizer,
  output logic lowPowerActive
);
  import pdpo_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  pdpo_pwr_t pwrQ;
  pdpo_pwr_t pwrD;
  pdpo_out_t outQ;
  pdpo_out_t outD;
  logic pdReqSync;
  logic readySync;
  logic [1:0] strapSync;
  pdpo_strap_t strapLevel;
  logic twosSel;
  logic stabSel;
  logic convOk;
  pdpo_word_if pipeIn();
  pdpo_word_if pipeOut();

  // Limits the front-end value to the code range instead of wrapping.
  function automatic pdpo_word_t clipCode(input pdpo_raw_t raw);
    pdpo_word_t code;
    if (raw < `PDPO_RAW_LO)
      code = `PDPO_CODE_ZERO;
    else if (raw > `PDPO_RAW_HI)
      code = `PDPO_CODE_FULL;
    else
      code = {~raw[`PDPO_WORD_MSB], raw[`PDPO_WORD_MSB-1:0]};
    return code;
  endfunction

  // ==========================================================
  // Power control, system clock domain
  // ==========================================================

  // The request pin is asynchronous, so it is synchronised first.
  pdpo_sync2 #(
    .W(1)
  ) uPdSync (
    .clk(clk),
    .nrst(nrst),
    .levelIn(lowPowerRequest),
    .levelOut(pdReqSync)
  );

  // Run, power down, then wait out the reference recharge time.
  always_comb
  begin
    pwrD = pwrQ;
    unique case (pwrQ.state)
      PDPO_PWR_RUN:
      begin
        if (pdReqSync)
        begin
          pwrD.state = PDPO_PWR_DOWN;
          pwrD.lowPower = 1'b1;
          pwrD.ready = 1'b0;
        end
      end
      PDPO_PWR_DOWN:
      begin
        if (!pdReqSync)
        begin
          pwrD.state = PDPO_PWR_WAKE;
          pwrD.lowPower = 1'b0;
          pwrD.count = `PDPO_CNT_W'(RECOVER_CYCLES - 1);
        end
      end
      PDPO_PWR_WAKE:
      begin
        if (pdReqSync)
        begin
          pwrD.state = PDPO_PWR_DOWN;
          pwrD.lowPower = 1'b1;
        end
        else if (pwrQ.count == '0)
        begin
          pwrD.state = PDPO_PWR_RUN;
          pwrD.ready = 1'b1;
        end
        else
          pwrD.count = pwrQ.count - 1'b1;
      end
      default:
      begin
        pwrD.state = PDPO_PWR_DOWN;
        pwrD.lowPower = 1'b1;
        pwrD.ready = 1'b0;
      end
    endcase
  end

  // Leaving reset counts as a settled converter, ready at once.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwrQ.state <= PDPO_PWR_RUN;
      pwrQ.count <= '0;
      pwrQ.lowPower <= 1'b0;
      pwrQ.ready <= 1'b1;
    end
    else
      pwrQ <= pwrD;
  end

  assign lowPowerActive = pwrQ.lowPower;

  // ==========================================================
  // Conversion path, sample clock domain
  // ==========================================================

  // Readiness is a level, so two flops carry it across.
  pdpo_sync2 #(
    .W(1)
  ) uReadySync (
    .clk(sampleClk),
    .nrst(nrst),
    .levelIn(pwrQ.ready),
    .levelOut(readySync)
  );

  // The strap is static; a change mid-run may spoil a few words.
  pdpo_sync2 #(
    .W(2)
  ) uStrapSync (
    .clk(sampleClk),
    .nrst(nrst),
    .levelIn(formatStabilizerStrap),
    .levelOut(strapSync)
  );

  // Decode the four strap levels into coding and stabilizer.
  assign strapLevel = pdpo_strap_t'(strapSync);
  assign twosSel = (strapLevel == PDPO_STRAP_SUPPLY) ||
    (strapLevel == PDPO_STRAP_TWO_THIRDS);
  assign stabSel = (strapLevel == PDPO_STRAP_THIRD) ||
    (strapLevel == PDPO_STRAP_TWO_THIRDS);
  assign convOk = readySync;

  // Each rising edge takes one clipped sample into the delay line.
  assign pipeIn.word = clipCode(rawCode);
  assign pipeIn.valid = convOk;

  // Powering down flushes the delay line, losing its contents.
  pdpo_pipeline uPipe (
    .clk(sampleClk),
    .nrst(nrst),
    .flush(~convOk),
    .stageIn(pipeIn),
    .stageOut(pipeOut)
  );

  // Coding is applied after the delay line, so one pipe serves both.
  always_comb
  begin
    outD.valid = pipeOut.valid & convOk;
    outD.stab = stabSel;
    if (!outD.valid)
      outD.word = `PDPO_CODE_ZERO;
    else if (twosSel)
      outD.word = {~pipeOut.word[`PDPO_WORD_MSB],
        pipeOut.word[`PDPO_WORD_MSB-1:0]};
    else
      outD.word = pipeOut.word;
  end

  // Output register, the seventh edge after the sampling edge.
  always_ff @(posedge sampleClk or negedge nrst)
  begin
    if (!nrst)
    begin
      outQ.word <= `PDPO_CODE_ZERO;
      outQ.valid <= 1'b0;
      outQ.stab <= 1'b0;
    end
    else
      outQ <= outD;
  end

  // Strobe rises mid-period, once the new word has settled.
  assign sampleValidStrobe = ~sampleClk & outQ.valid;
  assign sampleWordLines = outQ.word;
  assign dutyCycleStabilizer = outQ.stab;

  // ==========================================================
  // Assertions
  // ==========================================================

  sequence s_conv_run;
    convOk [*8];
  endsequence

  property p_word_rate;
    @(posedge sampleClk) disable iff (!nrst)
    s_conv_run |=> outQ.valid;
  endproperty
  a_word_rate:
    assert property (p_word_rate)
    else $error("Output word missing during steady conversion.");

  property p_latency;
    @(posedge sampleClk) disable iff (!nrst)
    outQ.valid |-> outQ.word[`PDPO_WORD_MSB-1:0] ==
      $past(pipeIn.word[`PDPO_WORD_MSB-1:0], `PDPO_PIPE_STAGES + 1);
  endproperty
  a_latency:
    assert property (p_latency)
    else $error("Output word does not match sample seven clocks back.");

  property p_fmt_twos;
    @(posedge sampleClk) disable iff (!nrst)
    (pipeOut.valid && convOk && twosSel) |=>
      (outQ.word == {~$past(pipeOut.word[`PDPO_WORD_MSB]),
        $past(pipeOut.word[`PDPO_WORD_MSB-1:0])});
  endproperty
  a_fmt_twos:
    assert property (p_fmt_twos)
    else $error("Two's complement word lacks inverted top bit.");

  property p_fmt_offset;
    @(posedge sampleClk) disable iff (!nrst)
    (pipeOut.valid && convOk && !twosSel) |=>
      (outQ.word == $past(pipeOut.word));
  endproperty
  a_fmt_offset:
    assert property (p_fmt_offset)
    else $error("Offset binary word altered at output.");

  property p_clip_low;
    @(posedge sampleClk) disable iff (!nrst)
    (rawCode < `PDPO_RAW_LO) |-> (pipeIn.word == `PDPO_CODE_ZERO);
  endproperty
  a_clip_low:
    assert property (p_clip_low)
    else $error("Under-range sample not clipped to negative full scale.");

  property p_clip_high;
    @(posedge sampleClk) disable iff (!nrst)
    (rawCode > `PDPO_RAW_HI) |-> (pipeIn.word == `PDPO_CODE_FULL);
  endproperty
  a_clip_high:
    assert property (p_clip_high)
    else $error("Over-range sample not clipped to positive full scale.");

  property p_quarter;
    @(posedge sampleClk) disable iff (!nrst)
    (rawCode == `PDPO_RAW_QTR_NEG) |-> (pipeIn.word == `PDPO_CODE_QTR);
  endproperty
  a_quarter:
    assert property (p_quarter)
    else $error("Quarter-range sample has wrong code.");

  property p_mid;
    @(posedge sampleClk) disable iff (!nrst)
    (rawCode == `PDPO_RAW_MID) |-> (pipeIn.word == `PDPO_CODE_MID);
  endproperty
  a_mid:
    assert property (p_mid)
    else $error("Mid-scale sample has wrong code.");

  property p_strobe_idle;
    @(posedge sampleClk) disable iff (!nrst)
    !outQ.valid |-> !sampleValidStrobe;
  endproperty
  a_strobe_idle:
    assert property (p_strobe_idle)
    else $error("Strobe active without a valid word.");

  property p_stabilizer;
    @(posedge sampleClk) disable iff (!nrst)
    ((strapLevel == PDPO_STRAP_THIRD) ||
      (strapLevel == PDPO_STRAP_TWO_THIRDS)) |=> dutyCycleStabilizer;
  endproperty
  a_stabilizer:
    assert property (p_stabilizer)
    else $error("Stabilizer not enabled for its strap levels.");

  property p_pd_flush;
    @(posedge sampleClk) disable iff (!nrst)
    !convOk |=> (!outQ.valid && outQ.word == `PDPO_CODE_ZERO);
  endproperty
  a_pd_flush:
    assert property (p_pd_flush)
    else $error("Word still valid while converter is not ready.");

  property p_pd_enter;
    @(posedge clk) disable iff (!nrst)
    (pdReqSync && pwrQ.state == PDPO_PWR_RUN) |=>
      (lowPowerActive && !pwrQ.ready);
  endproperty
  a_pd_enter:
    assert property (p_pd_enter)
    else $error("Power-down request did not enter low power.");

  property p_wake_hold;
    @(posedge clk) disable iff (!nrst)
    (pwrQ.state == PDPO_PWR_WAKE) |-> (!pwrQ.ready && !lowPowerActive);
  endproperty
  a_wake_hold:
    assert property (p_wake_hold)
    else $error("Converter ready before recovery ended.");

  property p_wake_time;
    @(posedge clk) disable iff (!nrst)
    $rose(pwrQ.ready) |->
      ($past(pwrQ.state) == PDPO_PWR_WAKE && $past(pwrQ.count) == '0);
  endproperty
  a_wake_time:
    assert property (p_wake_time)
    else $error("Ready raised before the recovery count ran out.");
endmodule
`default_nettype wire

// ### src/pdpo_sync2.sv
// Two-flop level synchroniser of configurable width.
`timescale 1ns/1ps
`default_nettype none
module pdpo_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] levelIn,
  output logic [W-1:0] levelOut
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } pdpo_sync_t;
  pdpo_sync_t syncQ;
  pdpo_sync_t syncD;

  // The first stage feeds only the second stage.
  always_comb
  begin
    syncD.meta = levelIn;
    syncD.held = syncQ.meta;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      syncQ <= '0;
    else
      syncQ <= syncD;
  end

  assign levelOut = syncQ.held;
endmodule
`default_nettype wire
